// File: core/ifpf_regs.svh
// Register map, field positions, reset values, limits and timing for the idle code packet field block
`ifndef IFPF_REGS_SVH
`define IFPF_REGS_SVH
// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define IFPF_CTRL_OFS 12'h000
`define IFPF_MAXOCT_OFS 12'h004
`define IFPF_STATUS_OFS 12'h008
// ----------------------------------------
// Field positions
// ----------------------------------------
`define IFPF_CTRL_RATE_LSB 0
`define IFPF_CTRL_MULTI_BIT 2
`define IFPF_CTRL_STRIP_BIT 3
`define IFPF_CTRL_COLLECT_BIT 4
`define IFPF_CTRL_TXTYPE_LSB 8
`define IFPF_CTRL_IDLEUPD_BIT 31
`define IFPF_STAT_RXTYPE_LSB 0
`define IFPF_STAT_BUILDOUT_BIT 4
`define IFPF_STAT_IDLEPLAY_BIT 5
`define IFPF_STAT_OVERRUN_BIT 6
`define IFPF_STAT_FILL_LSB 8
// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define IFPF_MAXOCT_RST 9'd133
`define IFPF_TYPE_RST 4'hf
`define IFPF_INFO_LIMIT 9'd482
`define IFPF_OCT_MULT 9'd7
`define IFPF_ORDER_IDLE 1'b0
`define IFPF_EQ_ALWAYS 1'b1
// ----------------------------------------
// Idle background type codes
// ----------------------------------------
`define IFPF_T_ZERO 4'h8
`define IFPF_T_ONES 4'hf
`define IFPF_T_FE 4'he
`define IFPF_T_ABN 4'hd
`define IFPF_T_UNAS 4'hc
`define IFPF_T_SYNC 4'ha
`define IFPF_T_NOIDLE 4'h7
// ----------------------------------------
// Idle octets, bit 1 is the MSB
// ----------------------------------------
`define IFPF_P_ONES 8'hff
`define IFPF_P_ZERO 8'h00
`define IFPF_P_FE 8'hfe
`define IFPF_P_ABN 8'h9e
`define IFPF_P_UNAS 8'h98
`define IFPF_P_SYNC 8'h9a
`define IFPF_P_ZSUP 8'h80
`define IFPF_P_NOIDLE 8'h21
`define IFPF_P_SUBMASK 8'h7f
// ----------------------------------------
// Timing
// ----------------------------------------
`define IFPF_CLK_NS 100
`define IFPF_BIT_NS 15625
`define IFPF_BIT_CYC (`IFPF_BIT_NS / `IFPF_CLK_NS)
`endif

// File: core/ifpf_pkg.sv
// Types shared by the idle code packet field block
package ifpf_pkg;
  // ----------------------------------------
  // Modes and states
  // ----------------------------------------
  typedef enum logic [1:0] {
    RATE_64 = 2'h0,
    RATE_56 = 2'h1,
    RATE_SUB = 2'h2,
    RATE_SUB2 = 2'h3
  } ifpf_rate_type;

  typedef enum logic [1:0] {
    PLAY_DATA = 2'b01,
    PLAY_IDLE = 2'b10
  } ifpf_play_type;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic last;
    logic [2:0] valid_count;
  } ifpf_word_type;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic [15:0] div_cnt;
    ifpf_rate_type rate;
    logic multipoint;
    logic strip_ctrl;
    logic collect_en;
    logic [3:0] tx_type;
    logic [8:0] max_info_octets;
    logic overrun;
    logic [3:0] rx_type;
    logic rx_eq_flag;
    ifpf_play_type play_state;
    logic [7:0] play_sr;
    logic [2:0] play_cnt;
    logic [7:0] col_sr;
    logic [3:0] col_cnt;
    logic [2:0] ch_pos;
    logic [8:0] oct_cnt;
    logic was_collecting;
    logic idle_upd_pend;
    ifpf_word_type [1:0] mem;
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] fill;
    logic [31:0] prdata;
    logic pslverr;
  } ifpf_state_type;
endpackage

// File: core/ifpf_top.sv
// Idle code packet field block: idle playout, octet collection, padding and APB registers
`include "ifpf_regs.svh"

// Summary of operation
// (RL1) 64k and multipoint idle types map to octets
// (RL2) 56k and subrate failure and normal idle octets
// (RL3) Idle octet played out bit 1 first
// (RL4) Equalize flag always one, enables build-out
// (RL5) Pad unfinished final octet with ones
// (RL6) Valid count 001..111 is 1..7, 000 eight
// (RL7) Max information octets a multiple of seven
// (RL8) Information field never exceeds 482 octets
// (RL9) Max octets default 133, per rate 7/14/28
// (RL10) Octets ascending, bit 1 sent first
// (RL11) Earliest channel bit is earliest packet bit
// (RL12) Idle update: empty field, order number zero
// (RL13) Idle octet from last received background type
// (RL14) Control-kept flag cleared when last bit stripped
// (RL15) Repeat idle octet until packet data resumes
module ifpf_top #(
  parameter logic [15:0] CH_DIV = 16'(`IFPF_BIT_CYC) // Clocks per channel bit
) (
  input wire logic pclk, // APB clock, 10 MHz
  input wire logic presetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic ch_rx_bit, // Channel serial data in
  output logic ch_tx_bit, // Channel serial data out
  output logic ch_bit_tick, // One-cycle channel bit strobe
  input wire logic rx_hdr_valid, // Received packet header strobe
  input wire logic [3:0] rx_idle_background_type, // Received background type
  input wire logic rx_delay_equalize_flag, // Received equalize flag
  input wire logic rx_valid, // Received information octet valid
  input wire logic [7:0] rx_data, // Received information octet
  output logic rx_ready, // Octet taken for playout
  output logic buildout_en, // Build-out delay handling enabled
  output ifpf_pkg::ifpf_word_type tx_word, // Collected information octet
  output logic tx_valid, // Collected octet valid
  input wire logic tx_ready, // Packet side accepts octet
  output logic tx_delay_equalize_flag, // Outgoing equalize flag
  output logic tx_ctrl_kept, // Outgoing control-bit-kept flag
  output logic [3:0] tx_idle_background_type, // Outgoing background type
  output logic idle_upd_valid, // Idle update packet request
  input wire logic idle_upd_ready, // Idle update packet accepted
  output logic idle_upd_order_zero // Order number of idle update
);
  import ifpf_pkg::*;

  ifpf_state_type st_r;
  ifpf_state_type st_nxt;
  logic tick;
  logic wr_acc;
  logic setup;
  logic push;
  logic pop;
  logic skip;
  logic oct_done;
  logic pad_done;
  logic [3:0] cnt_inc;
  logic [7:0] col_shift;
  logic [8:0] max_w;
  ifpf_word_type new_word;

  // ----------------------------------------
  // Idle octet lookup
  // ----------------------------------------
  function automatic logic [7:0] idle_octet(input ifpf_rate_type rate, input logic multi, input logic [3:0] t);
    logic [7:0] p;
    p = `IFPF_P_ONES;
    if (t == `IFPF_T_ZERO && rate == RATE_64) begin
      p = `IFPF_P_ZERO; // RL1
    end else if (multi) begin
      p = (t == `IFPF_T_FE) ? `IFPF_P_FE : `IFPF_P_ONES; // RL1
    end else if (t == `IFPF_T_NOIDLE) begin
      p = `IFPF_P_NOIDLE;
    end else begin
      case (t)
        `IFPF_T_FE: p = `IFPF_P_FE; // RL1
        `IFPF_T_ABN: p = `IFPF_P_ABN; // RL2
        `IFPF_T_UNAS: p = `IFPF_P_UNAS; // RL2
        `IFPF_T_SYNC: p = `IFPF_P_SYNC; // RL2
        `IFPF_T_ZERO: p = `IFPF_P_ZSUP; // RL2
        default: p = `IFPF_P_ONES;
      endcase
      // Subrate patterns are the 56k ones with bit 1 cleared
      if (rate == RATE_SUB || rate == RATE_SUB2) begin
        p = p & `IFPF_P_SUBMASK; // RL2
      end
    end
    return p;
  endfunction

  // ----------------------------------------
  // Combinational helpers
  // ----------------------------------------
  assign tick = (st_r.div_cnt == 16'h0000);
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign max_w = pwdata[8:0];
  // Last channel bit of each octet is dropped when stripping is on
  assign skip = st_r.strip_ctrl && (st_r.ch_pos == 3'h7); // RL14
  assign cnt_inc = st_r.col_cnt + 4'h1;
  assign oct_done = tick && st_r.collect_en && !skip && (cnt_inc == 4'h8);
  assign pad_done = st_r.was_collecting && !st_r.collect_en && (st_r.col_cnt != 4'h0);
  // Earliest bit ends in the MSB, which goes out first on the packet side
  assign col_shift = {st_r.col_sr[6:0], st_r.sync2}; // RL11 RL10
  assign push = oct_done || pad_done;
  assign pop = tx_ready && (st_r.fill != 2'h0);

  // Octet to queue: full octet, or a partial one padded with ones
  always_comb begin
    new_word.data = col_shift;
    new_word.valid_count = 3'h0; // RL6
    new_word.last = ((st_r.oct_cnt + 9'h001) == st_r.max_info_octets);
    if (pad_done) begin
      new_word.data = (st_r.col_sr << (4'h8 - st_r.col_cnt)) | (8'hff >> st_r.col_cnt); // RL5
      new_word.valid_count = st_r.col_cnt[2:0]; // RL6
      new_word.last = 1'b1;
    end
  end

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = ch_rx_bit;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.div_cnt = tick ? (CH_DIV - 16'h0001) : (st_r.div_cnt - 16'h0001);
    st_nxt.was_collecting = st_r.collect_en;

    // Header fields from the last received packet: the type picks the idle octet, the flag sets build-out
    if (rx_hdr_valid) begin
      st_nxt.rx_type = rx_idle_background_type; // RL13
      st_nxt.rx_eq_flag = rx_delay_equalize_flag; // RL4
    end

    // Playout: shift MSB first, reload after bit 8
    if (tick) begin
      st_nxt.play_sr = {st_r.play_sr[6:0], 1'b1}; // RL3
      st_nxt.play_cnt = st_r.play_cnt + 3'h1;
      if (st_r.play_cnt == 3'h7) begin
        if (rx_valid) begin
          st_nxt.play_sr = rx_data;
          st_nxt.play_state = PLAY_DATA;
        end else begin
          // Keeps repeating while no data arrives
          st_nxt.play_sr = idle_octet(st_r.rate, st_r.multipoint, st_r.rx_type); // RL13 RL15
          st_nxt.play_state = PLAY_IDLE;
        end
      end
    end

    // Collector: gather channel bits into octets
    if (tick && st_r.collect_en) begin
      st_nxt.ch_pos = st_r.ch_pos + 3'h1;
      if (!skip) begin
        st_nxt.col_sr = col_shift;
        st_nxt.col_cnt = oct_done ? 4'h0 : cnt_inc;
      end
    end
    if (pad_done) begin
      st_nxt.col_cnt = 4'h0;
      st_nxt.ch_pos = 3'h0;
    end
    if (push) begin
      // Packet boundary at the configured octet count
      st_nxt.oct_cnt = new_word.last ? 9'h000 : (st_r.oct_cnt + 9'h001); // RL7 RL8
    end

    // Two-entry buffer; a full buffer drops the word and flags it
    if (pop) begin
      st_nxt.rd_ptr = ~st_r.rd_ptr;
    end
    if (push && (st_r.fill != 2'h2 || pop)) begin
      st_nxt.mem[st_r.wr_ptr] = new_word;
      st_nxt.wr_ptr = ~st_r.wr_ptr;
    end
    if (push && st_r.fill == 2'h2 && !pop) begin
      st_nxt.fill = st_r.fill;
    end else begin
      st_nxt.fill = st_r.fill + {1'b0, push} - {1'b0, pop};
    end

    // Idle update request clears on acceptance
    if (idle_upd_ready) begin
      st_nxt.idle_upd_pend = 1'b0;
    end

    // ----------------------------------------
    // APB register access
    // ----------------------------------------
    st_nxt.pslverr = 1'b0;
    if (setup) begin
      st_nxt.prdata = 32'h0000_0000;
      case (paddr)
        `IFPF_CTRL_OFS: begin
          st_nxt.prdata[`IFPF_CTRL_RATE_LSB +: 2] = st_r.rate;
          st_nxt.prdata[`IFPF_CTRL_MULTI_BIT] = st_r.multipoint;
          st_nxt.prdata[`IFPF_CTRL_STRIP_BIT] = st_r.strip_ctrl;
          st_nxt.prdata[`IFPF_CTRL_COLLECT_BIT] = st_r.collect_en;
          st_nxt.prdata[`IFPF_CTRL_TXTYPE_LSB +: 4] = st_r.tx_type;
        end
        `IFPF_MAXOCT_OFS: st_nxt.prdata[8:0] = st_r.max_info_octets;
        `IFPF_STATUS_OFS: begin
          st_nxt.prdata[`IFPF_STAT_RXTYPE_LSB +: 4] = st_r.rx_type;
          st_nxt.prdata[`IFPF_STAT_BUILDOUT_BIT] = st_r.rx_eq_flag;
          st_nxt.prdata[`IFPF_STAT_IDLEPLAY_BIT] = (st_r.play_state == PLAY_IDLE);
          st_nxt.prdata[`IFPF_STAT_OVERRUN_BIT] = st_r.overrun;
          st_nxt.prdata[`IFPF_STAT_FILL_LSB +: 2] = st_r.fill;
        end
        default: st_nxt.pslverr = 1'b1;
      endcase
      // A bad octet count is refused at setup so the error shows in access
      if (pwrite && paddr == `IFPF_MAXOCT_OFS) begin
        if (max_w == 9'h000 || max_w > `IFPF_INFO_LIMIT || (max_w % `IFPF_OCT_MULT) != 9'h000) begin
          st_nxt.pslverr = 1'b1; // RL7 RL8
        end
      end
    end else if (psel && penable) begin
      st_nxt.pslverr = st_r.pslverr;
    end
    if (wr_acc && !st_r.pslverr) begin
      case (paddr)
        `IFPF_CTRL_OFS: begin
          st_nxt.rate = ifpf_rate_type'(pwdata[`IFPF_CTRL_RATE_LSB +: 2]);
          st_nxt.multipoint = pwdata[`IFPF_CTRL_MULTI_BIT];
          st_nxt.strip_ctrl = pwdata[`IFPF_CTRL_STRIP_BIT];
          st_nxt.collect_en = pwdata[`IFPF_CTRL_COLLECT_BIT];
          st_nxt.tx_type = pwdata[`IFPF_CTRL_TXTYPE_LSB +: 4];
          if (pwdata[`IFPF_CTRL_IDLEUPD_BIT]) begin
            st_nxt.idle_upd_pend = 1'b1;
          end
        end
        `IFPF_MAXOCT_OFS: st_nxt.max_info_octets = max_w; // RL7 RL9
        `IFPF_STATUS_OFS: begin
          if (pwdata[`IFPF_STAT_OVERRUN_BIT]) begin
            st_nxt.overrun = 1'b0;
          end
        end
        default: st_nxt.overrun = st_r.overrun;
      endcase
    end
    // Overrun set wins over a clear in the same cycle
    if (push && st_r.fill == 2'h2 && !pop) begin
      st_nxt.overrun = 1'b1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
      st_r.sync1 <= 1'b1;
      st_r.sync2 <= 1'b1;
      st_r.rate <= RATE_64;
      st_r.max_info_octets <= `IFPF_MAXOCT_RST; // RL9
      st_r.tx_type <= `IFPF_TYPE_RST;
      st_r.rx_type <= `IFPF_TYPE_RST;
      st_r.rx_eq_flag <= `IFPF_EQ_ALWAYS;
      st_r.play_state <= PLAY_IDLE;
      st_r.play_sr <= `IFPF_P_ONES;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = st_r.prdata;
  assign pready = 1'b1;
  assign pslverr = st_r.pslverr && psel && penable;
  assign ch_tx_bit = st_r.play_sr[7]; // RL3
  assign ch_bit_tick = tick;
  assign rx_ready = tick && (st_r.play_cnt == 3'h7) && rx_valid;
  assign buildout_en = st_r.rx_eq_flag; // RL4
  assign tx_word = st_r.mem[st_r.rd_ptr];
  assign tx_valid = (st_r.fill != 2'h0);
  assign tx_delay_equalize_flag = `IFPF_EQ_ALWAYS; // RL4
  assign tx_ctrl_kept = ~st_r.strip_ctrl; // RL14
  assign tx_idle_background_type = st_r.tx_type;
  assign idle_upd_valid = st_r.idle_upd_pend; // RL12
  assign idle_upd_order_zero = `IFPF_ORDER_IDLE; // RL12
endmodule // ifpf_top

// File: verif/ifpf_props.sv
// Concurrent checks on the ports of the idle code packet field block
`include "ifpf_regs.svh"
module ifpf_props (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic psel, // Select
  input wire logic penable, // Enable
  input wire logic pwrite, // Direction
  input wire logic [11:0] paddr, // Address
  input wire logic [31:0] pwdata, // Write data
  input wire logic pslverr, // Error
  input wire logic ch_tx_bit, // Serial out
  input wire logic ch_bit_tick, // Bit strobe
  input wire logic rx_hdr_valid, // Header strobe
  input wire logic rx_delay_equalize_flag, // Received flag
  input wire logic buildout_en, // Build-out on
  input wire ifpf_pkg::ifpf_word_type tx_word, // Collected octet
  input wire logic tx_valid, // Octet valid
  input wire logic tx_ready, // Octet taken
  input wire logic tx_delay_equalize_flag, // Outgoing flag
  input wire logic idle_upd_valid, // Update request
  input wire logic idle_upd_ready, // Update taken
  input wire logic idle_upd_order_zero // Update order number
);
  import ifpf_pkg::*;
  logic oct_wr;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------
  // Assertions
  // ------
  // Only the nine low bits hold the count, so the limits are judged there
  assign oct_wr = psel && penable && pwrite && paddr == `IFPF_MAXOCT_OFS;
  chk_limit_refused: assert property (oct_wr && pwdata[8:0] > `IFPF_INFO_LIMIT |-> pslverr)
    else $error("octet count above limit accepted");
  chk_multiple_refused: assert property (oct_wr && pwdata[8:0] % `IFPF_OCT_MULT != 9'h0 |-> pslverr)
    else $error("octet count not a multiple of seven accepted");
  chk_eq_set: assert property (tx_delay_equalize_flag == `IFPF_EQ_ALWAYS)
    else $error("outgoing equalize flag low");
  chk_buildout_follow: assert property (rx_hdr_valid |=> buildout_en == $past(rx_delay_equalize_flag))
    else $error("build-out enable does not follow header flag");
  chk_upd_held: assert property (idle_upd_valid && !idle_upd_ready |=> idle_upd_valid)
    else $error("idle update request dropped early");
  chk_upd_empty: assert property (idle_upd_valid |-> idle_upd_order_zero == `IFPF_ORDER_IDLE)
    else $error("idle update order number not zero");
  chk_word_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word))
    else $error("collected octet changed while stalled");
  chk_pad_ones: assert property (tx_valid && tx_word.valid_count != 3'h0 |-> tx_word.last &&
    (tx_word.data & (8'hff >> tx_word.valid_count)) == (8'hff >> tx_word.valid_count))
    else $error("final octet padding wrong");
  chk_bit_on_tick: assert property ($changed(ch_tx_bit) |-> $past(ch_bit_tick))
    else $error("serial out moved without a bit strobe");
  cov_last: cover property (tx_valid && tx_ready && tx_word.last);
  cov_upd: cover property (idle_upd_valid && idle_upd_ready);
  cov_err: cover property (pslverr);
  cov_pad: cover property (tx_valid && tx_ready && tx_word.valid_count != 3'h0);
endmodule // ifpf_props

bind ifpf_top ifpf_props chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .ch_tx_bit,
  .ch_bit_tick, .rx_hdr_valid, .rx_delay_equalize_flag, .buildout_en, .tx_word, .tx_valid, .tx_ready,
  .tx_delay_equalize_flag, .idle_upd_valid, .idle_upd_ready, .idle_upd_order_zero);

// File: verif/ifpf_peer.sv
// Peer packet endpoint model facing the packet side of the block
module ifpf_peer (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, active low
  input wire logic send_go, // Bench asks for one octet
  input wire logic [7:0] send_data, // Octet to offer
  input wire logic stall, // Hold off collected octets
  output logic rx_valid, // Octet offered
  output logic [7:0] rx_data, // Offered octet
  input wire logic rx_ready, // Octet taken
  input wire ifpf_pkg::ifpf_word_type tx_word, // Collected octet
  input wire logic tx_valid, // Collected octet valid
  output logic tx_ready, // Accept collected octet
  input wire logic idle_upd_valid, // Idle update request
  output logic idle_upd_ready // Idle update accepted
);
  import ifpf_pkg::*;
  ifpf_word_type got_q[$];
  // Offer held until taken; released data toggles so a stale octet never looks valid
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
      tx_ready <= 1'b0;
      idle_upd_ready <= 1'b0;
    end else begin
      if (send_go) begin
        rx_valid <= 1'b1;
        rx_data <= send_data;
      end else if (rx_valid && rx_ready) begin
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
      end else if (!rx_valid) begin
        rx_data <= ~rx_data;
      end
      tx_ready <= !stall;
      idle_upd_ready <= idle_upd_valid && !idle_upd_ready;
      if (tx_valid && tx_ready) begin
        got_q.push_back(tx_word);
      end
    end
  end
endmodule // ifpf_peer

// File: verif/ifpf_top_tb.sv
// Self-checking bench for the idle code packet field block
`include "ifpf_regs.svh"
module ifpf_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ifpf_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, ch_rx_bit, rx_hdr_valid, rx_delay_equalize_flag, send_go, stall;
  logic pready, pslverr, ch_tx_bit, ch_bit_tick, rx_valid, rx_ready, buildout_en, tx_valid, tx_ready;
  logic tx_delay_equalize_flag, tx_ctrl_kept, idle_upd_valid, idle_upd_ready, idle_upd_order_zero;
  logic [3:0] rx_idle_background_type, tx_idle_background_type;
  logic [7:0] rx_data, send_data;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  ifpf_word_type tx_word;
  int num_errors = 0;
  int checks_done = 0;
  // Rate, multipoint, received type, expected idle octet
  logic [19:0] ptab[20] = '{20'h00800, 20'h00fff, 20'h00efe, 20'h01800, 20'h10d9e, 20'h10c98, 20'h10a9a,
    20'h10880, 20'h10fff, 20'h10efe, 20'h10721, 20'h20d1e, 20'h20c18, 20'h20a1a, 20'h20800, 20'h20f7f,
    20'h20e7e, 20'h30d1e, 20'h11dff, 20'h21efe};
  logic [31:0] okv[4] = '{32'h7, 32'he, 32'h1c, 32'h85};
  logic [31:0] badv[3] = '{32'h1ea, 32'ha, 32'h0};
  // Short bit period keeps each octet to 32 clocks
  ifpf_top #(.CH_DIV(16'h0004)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ch_rx_bit, .ch_tx_bit, .ch_bit_tick, .rx_hdr_valid, .rx_idle_background_type, .rx_delay_equalize_flag,
    .rx_valid, .rx_data, .rx_ready, .buildout_en, .tx_word, .tx_valid, .tx_ready, .tx_delay_equalize_flag,
    .tx_ctrl_kept, .tx_idle_background_type, .idle_upd_valid, .idle_upd_ready, .idle_upd_order_zero);
  ifpf_peer peer_u (.pclk, .presetn, .send_go, .send_data, .stall, .rx_valid, .rx_data, .rx_ready, .tx_word,
    .tx_valid, .tx_ready, .idle_upd_valid, .idle_upd_ready);
  // ------
  // Tasks
  // ------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      num_errors++;
      $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // One APB transfer; the trailing edge keeps two requests from sharing a step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    x = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic e);
    logic [31:0] r;
    logic x;
    apb(1'b1, a, d, r, x);
    check({31'h0, x}, {31'h0, e});
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] w, input logic [31:0] m, input logic e);
    logic [31:0] r;
    logic x;
    apb(1'b0, a, 32'h0, r, x);
    check(r & m, w);
    check({31'h0, x}, {31'h0, e});
  endtask
  // Feeds k bits, first bit in p[7], one per bit strobe, aligned to the octet after the next push
  task automatic feed(input logic [7:0] p, input int k);
    int t;
    t = 0;
    do @(negedge pclk); while (tx_valid !== 1'b1 && t++ < 200);
    check({31'h0, tx_valid}, 32'h1);
    for (int b = 7; b > 7 - k; b--) begin
      if (b < 7) begin
        do @(negedge pclk); while (ch_bit_tick !== 1'b1);
      end
      @(posedge pclk);
      ch_rx_bit <= p[b];
    end
    do @(negedge pclk); while (ch_bit_tick !== 1'b1);
    @(posedge pclk);
  endtask
  task automatic wrap_up();
    if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ------
  // Clock, watchdog and sequence
  // ------
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  // Whole run needs about 2500 clocks; allow eight times that
  initial begin
    #2000000;
    num_errors++;
    wrap_up();
  end
  initial begin
    logic [19:0] e;
    logic [15:0] bits;
    int n;
    {presetn, psel, penable, pwrite, ch_rx_bit, rx_hdr_valid, rx_delay_equalize_flag, send_go, stall} = 9'h0;
    {paddr, pwdata, rx_idle_background_type, send_data} = 56'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`IFPF_CTRL_OFS, 32'hf00, 32'hffffffff, 1'b0);
    rd(`IFPF_MAXOCT_OFS, 32'h85, 32'hffffffff, 1'b0);
    rd(`IFPF_STATUS_OFS, 32'h1f, 32'h1f, 1'b0);
    rd(12'h00c, 32'h0, 32'hffffffff, 1'b1);
    for (int i = 0; i < 4; i++) begin
      wr(`IFPF_MAXOCT_OFS, okv[i], 1'b0);
      rd(`IFPF_MAXOCT_OFS, okv[i], 32'hffffffff, 1'b0);
    end
    for (int i = 0; i < 3; i++) begin
      wr(`IFPF_MAXOCT_OFS, badv[i], 1'b1);
      rd(`IFPF_MAXOCT_OFS, 32'h85, 32'hffffffff, 1'b0);
    end
    // One data octet, then the idle octet of the latched type
    for (int i = 0; i < 20; i++) begin
      e = ptab[i];
      wr(`IFPF_CTRL_OFS, {20'h0, 4'hf, 5'h0, e[12], e[17:16]}, 1'b0);
      rx_idle_background_type <= e[11:8];
      rx_delay_equalize_flag <= i[0];
      rx_hdr_valid <= 1'b1;
      @(posedge pclk);
      rx_hdr_valid <= 1'b0;
      send_data <= 8'hc5 ^ i[7:0];
      send_go <= 1'b1;
      @(posedge pclk);
      send_go <= 1'b0;
      check({31'h0, buildout_en}, {31'h0, i[0]});
      n = 0;
      do @(negedge pclk); while (rx_ready !== 1'b1 && n++ < 100);
      check({31'h0, rx_ready}, 32'h1);
      for (int b = 0; b < 16; b++) begin
        do @(negedge pclk); while (ch_bit_tick !== 1'b1);
        bits = {bits[14:0], ch_tx_bit};
      end
      check({16'h0, bits}, {16'h0, 8'hc5 ^ i[7:0], e[7:0]});
      @(posedge pclk);
      rd(`IFPF_STATUS_OFS, {28'h0, e[11:8]}, 32'hf, 1'b0);
    end
    // Collect with control bit stripped; the seventh octet closes the packet
    wr(`IFPF_MAXOCT_OFS, 32'h7, 1'b0);
    wr(`IFPF_CTRL_OFS, 32'hd18, 1'b0);
    check({31'h0, tx_ctrl_kept}, 32'h0);
    check({28'h0, tx_idle_background_type}, 32'hd);
    n = 0;
    do @(posedge pclk); while (peer_u.got_q.size() < 7 && n++ < 600);
    wr(`IFPF_CTRL_OFS, 32'hd00, 1'b0);
    check({20'h0, peer_u.got_q[0]}, 32'h0);
    check({20'h0, peer_u.got_q[6]}, 32'h8);
    // Stalled receiver: buffer fills, overrun sticks until cleared
    stall <= 1'b1;
    wr(`IFPF_CTRL_OFS, 32'hf10, 1'b0);
    check({31'h0, tx_ctrl_kept}, 32'h1);
    feed(8'hb4, 8);
    repeat (200) @(posedge pclk);
    wr(`IFPF_CTRL_OFS, 32'hf00, 1'b0);
    rd(`IFPF_STATUS_OFS, 32'h240, 32'h340, 1'b0);
    n = peer_u.got_q.size();
    stall <= 1'b0;
    repeat (10) @(posedge pclk);
    check({20'h0, peer_u.got_q[n + 1]}, 32'hb40);
    wr(`IFPF_STATUS_OFS, 32'h40, 1'b0);
    rd(`IFPF_STATUS_OFS, 32'h0, 32'h340, 1'b0);
    // Three bits then a stop: they lead the final octet, ones fill the rest
    wr(`IFPF_CTRL_OFS, 32'hf10, 1'b0);
    feed(8'ha0, 3);
    wr(`IFPF_CTRL_OFS, 32'hf00, 1'b0);
    repeat (2) @(posedge pclk);
    check({20'h0, peer_u.got_q[$]}, 32'hbfb);
    // Idle update request
    wr(`IFPF_CTRL_OFS, 32'h80000f00, 1'b0);
    n = 0;
    do @(negedge pclk); while (idle_upd_valid !== 1'b1 && n++ < 20);
    check({31'h0, idle_upd_valid}, 32'h1);
    check({31'h0, idle_upd_order_zero}, 32'h0);
    check({31'h0, tx_delay_equalize_flag}, 32'h1);
    wrap_up();
  end
endmodule // ifpf_top_tb
